// *** shared/flash_host_pkg.sv ***
package flash_host_pkg;
	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int WORD_W = 16;
	localparam int LANE_W = 8;
	localparam int NDEV   = 4;
	localparam logic [ADDR_W-1:0] LAST_ADDR = 17'h1FFFF;
	localparam logic [ADDR_W-1:0] ZERO_ADDR = 17'h00000;
	// ----------------------------------------
	// command codes and cell data patterns
	// ----------------------------------------
	localparam logic [LANE_W-1:0] CMD_READ   = 8'h00;
	localparam logic [LANE_W-1:0] CMD_ERASE  = 8'h20;
	localparam logic [LANE_W-1:0] CMD_PROG   = 8'h40;
	localparam logic [LANE_W-1:0] CMD_EVFY   = 8'hA0;
	localparam logic [LANE_W-1:0] CMD_PVFY   = 8'hC0;
	localparam logic [LANE_W-1:0] CMD_RESET  = 8'hFF;
	localparam logic [LANE_W-1:0] ERASED     = 8'hFF;
	localparam logic [LANE_W-1:0] CHARGED    = 8'h00;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ      = 40;
	localparam int PVFY_US      = 6;
	localparam int ERASE_MS     = 10;
	localparam int PVFY_CYC     = PVFY_US * CLK_MHZ;
	localparam int ERASE_CYC    = ERASE_MS * 1000 * CLK_MHZ;
	localparam int PULSE_CYC    = 4;
	localparam int MAX_PROG_TRY = 25;
	localparam int TIMER_W      = 20;
	localparam int TRY_W        = 5;
	// ----------------------------------------
	// host commands
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_READ    = 2'b00,
		OP_PROGRAM = 2'b01,
		OP_ERASE   = 2'b10,
		OP_PERASE  = 2'b11
	} op_e;
endpackage

// *** test/flash_dev_model.sv ***
`timescale 1ns/10ps
module flash_dev_model (
	input  wire logic        supply_high,     // programming supply
	input  wire logic        fail_prog,       // programming does not stick
	input  wire logic [3:0]  device_select_n, // chip enables
	input  wire logic        we_n,            // write enable
	input  wire logic        oe_n,            // output enable
	input  wire logic [16:0] location_lines,  // address
	input  wire logic [15:0] word_out,        // host data
	output logic      [15:0] word_in          // data toward host
);
	logic [7:0]  mem [int];
	logic [7:0]  cmd [4] = '{default: 8'h00};
	logic [16:0] wa [4];
	logic [16:0] lat [4];
	logic [3:0]  armed = 4'h0;
	logic [3:0]  erased = 4'h0;
	time         t_vfy [4];
	int          viol = 0;
	int          pulses = 0;
	int          erase_cnt [4] = '{default: 0};
	initial word_in = 16'h0000;
	function automatic logic [7:0] rd_byte(int d);
		logic [16:0] a;
		a = location_lines;
		if (supply_high) begin
			if (cmd[d] == 8'hC0 || cmd[d] == 8'hA0) begin
				a = lat[d];
				if (cmd[d] == 8'hC0 && $time - t_vfy[d] < 6000) viol++;
			end else if (cmd[d] != 8'h00) viol++;
		end
		if (mem.exists((d << 17) + int'(a))) return mem[(d << 17) + int'(a)];
		return erased[d] ? 8'hFF : (a[7:0] ^ 8'h5A ^ 8'(d));
	endfunction
	always @(negedge oe_n) begin
		for (int d = 0; d < 4; d++)
			if (!device_select_n[d]) word_in[8*(d%2) +: 8] = rd_byte(d);
	end
	// released bus shows no stale data
	always @(posedge oe_n) word_in = ~word_in;
	always @(negedge we_n) begin
		for (int d = 0; d < 4; d++)
			if (!device_select_n[d]) wa[d] = location_lines;
	end
	always @(posedge we_n) begin
		logic [7:0] b;
		int q[$];
		for (int d = 0; d < 4; d++) begin
			b = word_out[8*(d%2) +: 8];
			if (!device_select_n[d] && supply_high) begin
				if (armed[d]) begin
					if (!fail_prog) mem[(d << 17) + int'(wa[d])] = b;
					lat[d] = wa[d];
					armed[d] = 1'b0;
					b = 8'h40;
				end else begin
					if (b == 8'h40) armed[d] = 1'b1;
					if (b == 8'hC0) t_vfy[d] = $time;
					if (b == 8'hC0) pulses++;
					if (b == 8'hA0) lat[d] = wa[d];
					if (b == 8'h20 && cmd[d] == 8'h20) begin
						q.delete();
						foreach (mem[k]) if ((k >> 17) == d) q.push_back(k);
						foreach (q[i]) mem.delete(q[i]);
						erased[d] = 1'b1;
						erase_cnt[d]++;
						b = 8'hEE;
					end
				end
				cmd[d] = b;
			end
		end
	end
	always @(negedge supply_high) begin
		cmd = '{default: 8'h00};
		armed = 4'h0;
	end
endmodule

// *** test/flash_host_bench.sv ***
`timescale 1ns/10ps
module flash_host_bench;
	logic                mclk = 1'b0;
	logic                rst_n, cmd_valid, supply_high, fail_prog;
	flash_host_pkg::op_e cmd_op;
	logic [1:0]          cmd_dev;
	logic [16:0]         cmd_addr;
	logic [7:0]          cmd_data, v;
	logic [15:0]         word_in, word_out;
	logic                cmd_ready, rsp_valid, rsp_fail, we_n, oe_n, word_oe;
	logic [7:0]          rsp_data;
	logic [3:0]          device_select_n, ers;
	logic [16:0]         location_lines;
	logic [16:0]         pa [4];
	logic [7:0]          eb [int];
	int                  n_errors = 0, total_checks = 0, c0;
	always #12.5 mclk = ~mclk;
	flash_host u_flash_host (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .supply_high(supply_high),
		.word_in(word_in), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_fail(rsp_fail),
		.rsp_data(rsp_data), .device_select_n(device_select_n), .we_n(we_n), .oe_n(oe_n),
		.location_lines(location_lines), .word_out(word_out), .word_oe(word_oe));
	flash_dev_model u_flash_dev_model (.supply_high(supply_high), .fail_prog(fail_prog),
		.device_select_n(device_select_n), .we_n(we_n), .oe_n(oe_n),
		.location_lines(location_lines), .word_out(word_out), .word_in(word_in));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] exp_byte(int d, logic [16:0] a);
		if (eb.exists((d << 17) + int'(a))) return eb[(d << 17) + int'(a)];
		return ers[d] ? 8'hFF : (a[7:0] ^ 8'h5A ^ 8'(d));
	endfunction
	task automatic issue(flash_host_pkg::op_e op, int d, logic [16:0] a, logic [7:0] x);
		int n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		cmd_op = op;
		cmd_dev = 2'(d);
		cmd_addr = a;
		cmd_data = x;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
	endtask
	task automatic do_op(flash_host_pkg::op_e op, int d, logic [16:0] a, logic [7:0] x);
		int n = 0;
		issue(op, d, a, x);
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(16'(rsp_valid), 16'h0001);
		@(negedge mclk);
	endtask
	task automatic read_all;
		for (int d = 0; d < 4; d++) begin
			do_op(flash_host_pkg::OP_READ, d, pa[d], 8'h00);
			check(16'(rsp_data), 16'(exp_byte(d, pa[d])));
		end
	endtask
	task automatic reset_host;
		rst_n = 1'b0;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		check(16'(device_select_n), 16'h000F);
		repeat (2) @(negedge mclk);
	endtask
	// starts an erase, confirms only the masked devices erased, then aborts
	task automatic erase_abort(flash_host_pkg::op_e op, int d, logic [3:0] m);
		int base [4];
		int n = 0;
		base = u_flash_dev_model.erase_cnt;
		issue(op, d, 17'h00000, 8'h00);
		while (u_flash_dev_model.erase_cnt[d] == base[d] && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		repeat (20) @(negedge mclk);
		for (int i = 0; i < 4; i++) begin
			check(16'(u_flash_dev_model.erase_cnt[i] - base[i]), 16'(m[i]));
			if (m[i]) ers[i] = 1'b1;
			if (m[i]) eb.delete((i << 17) + int'(pa[i]));
		end
		reset_host();
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = flash_host_pkg::OP_READ;
		cmd_dev = 2'h0;
		cmd_addr = 17'h00000;
		cmd_data = 8'h00;
		supply_high = 1'b0;
		fail_prog = 1'b0;
		ers = 4'h0;
		void'($urandom(32'hAA248D8D));
		for (int d = 0; d < 4; d++) pa[d] = 17'($urandom);
		@(negedge mclk);
		reset_host();
		read_all();
		for (int o = 1; o < 4; o++) begin
			do_op(flash_host_pkg::op_e'(o), o, pa[o], 8'h00);
			check(16'(rsp_fail), 16'h0001);
		end
		supply_high = 1'b1;
		for (int d = 0; d < 4; d++) begin
			v = 8'($urandom);
			do_op(flash_host_pkg::OP_PROGRAM, d, pa[d], v);
			check({7'h00, rsp_fail, rsp_data}, {8'h00, v});
			eb[(d << 17) + int'(pa[d])] = v;
		end
		read_all();
		check(16'(u_flash_dev_model.viol), 16'h0000);
		c0 = u_flash_dev_model.pulses;
		fail_prog = 1'b1;
		do_op(flash_host_pkg::OP_PROGRAM, 2, pa[2] + 17'h00001, ~exp_byte(2, pa[2] + 17'h00001));
		check(16'(rsp_fail), 16'h0001);
		check(16'(u_flash_dev_model.pulses - c0), 16'h0019);
		fail_prog = 1'b0;
		c0 = int'($urandom % 4);
		do_op(flash_host_pkg::OP_PROGRAM, c0, pa[c0], flash_host_pkg::CHARGED);
		check(16'(rsp_fail), 16'h0000);
		eb[(c0 << 17) + int'(pa[c0])] = flash_host_pkg::CHARGED;
		erase_abort(flash_host_pkg::OP_ERASE, c0, 4'(1 << c0));
		erase_abort(flash_host_pkg::OP_PERASE, 0, 4'h3);
		supply_high = 1'b0;
		read_all();
		stop_test();
	end
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		stop_test();
	end
endmodule
bind flash_host flash_host_sva u_flash_host_sva (.mclk(mclk), .rst_n(rst_n),
	.cmd_valid(cmd_valid), .cmd_op(cmd_op), .supply_high(supply_high), .cmd_ready(cmd_ready),
	.rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .device_select_n(device_select_n),
	.we_n(we_n), .oe_n(oe_n), .location_lines(location_lines), .word_out(word_out),
	.word_oe(word_oe));

// *** test/flash_host_sva.sv ***
`timescale 1ns/10ps
module flash_host_sva (
	input wire logic                mclk,            // clock
	input wire logic                rst_n,           // async reset
	input wire logic                cmd_valid,       // start operation
	input wire flash_host_pkg::op_e cmd_op,          // operation
	input wire logic                supply_high,     // programming supply up
	input wire logic                cmd_ready,       // idle
	input wire logic                rsp_valid,       // done pulse
	input wire logic                rsp_fail,        // failed
	input wire logic [3:0]          device_select_n, // chip enables
	input wire logic                we_n,            // write enable
	input wire logic                oe_n,            // output enable
	input wire logic [16:0]         location_lines,  // address
	input wire logic [15:0]         word_out,        // host data
	input wire logic                word_oe          // data enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence s_refused;
		cmd_ready && cmd_valid && !supply_high && cmd_op != flash_host_pkg::OP_READ;
	endsequence
	sequence s_wr_pulse;
		(!we_n)[*4] ##1 we_n;
	endsequence
	sequence s_rd_pulse;
		(!oe_n)[*4] ##1 oe_n;
	endsequence
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_refuse_low: assert property (s_refused |-> ##[1:3] (rsp_valid && rsp_fail))
		else $error("refused op did not answer with failure");
	a_refuse_quiet: assert property (s_refused |=> (device_select_n == 4'hF)[*3])
		else $error("refused op selected a device");
	a_write_supply: assert property ($fell(we_n) |-> supply_high)
		else $error("write strobe at low supply");
	a_write_width: assert property ($fell(we_n) |-> s_wr_pulse)
		else $error("write strobe width wrong");
	a_read_width: assert property ($fell(oe_n) |-> s_rd_pulse)
		else $error("read strobe width wrong");
	a_strobe_clash: assert property (!(!we_n && !oe_n))
		else $error("write and read strobes together");
	a_write_hold: assert property (!we_n |-> word_oe && $stable(location_lines)
		&& $stable(word_out) && $stable(device_select_n))
		else $error("write cycle lines moved");
	a_read_float: assert property (!oe_n |-> !word_oe && device_select_n != 4'hF)
		else $error("read cycle bus fight or no select");
	a_lane_mask: assert property ((!we_n && device_select_n == 4'hE)
		|-> word_out[15:8] == 8'hFF)
		else $error("unused lane not idle code");
endmodule

// *** verilog/flash_bus_cycle.sv ***
`timescale 1ns/10ps
module flash_bus_cycle (
	input  wire logic                                  mclk,       // clock
	input  wire logic                                  rst_n,      // async reset
	input  wire logic                                  start,      // begin one bus cycle
	input  wire logic                                  is_write,   // 1 write, 0 read
	input  wire logic [flash_host_pkg::NDEV-1:0]       sel,        // devices to enable
	input  wire logic [flash_host_pkg::ADDR_W-1:0]     addr,       // location
	input  wire logic [flash_host_pkg::WORD_W-1:0]     wdata,      // word to write
	input  wire logic [flash_host_pkg::WORD_W-1:0]     word_in,    // bus from module
	output logic                                       done,       // cycle complete pulse
	output logic [flash_host_pkg::WORD_W-1:0]          rdata,      // captured read word
	output logic [flash_host_pkg::NDEV-1:0]            dev_sel_n,  // chip enables
	output logic                                       we_n,       // write enable
	output logic                                       oe_n,       // output enable
	output logic [flash_host_pkg::ADDR_W-1:0]          loc,        // location lines
	output logic [flash_host_pkg::WORD_W-1:0]          word_out,   // data to module
	output logic                                       word_oe     // drive data bus
);
	logic [2:0] cnt_r;
	logic       busy_r;
	logic       wr_r;

	// ----------------------------------------
	// strobe sequencer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r    <= 1'b0;
			wr_r      <= 1'b0;
			cnt_r     <= 3'h0;
			done      <= 1'b0;
			rdata     <= 16'h0000;
			dev_sel_n <= 4'hF;
			we_n      <= 1'b1;
			oe_n      <= 1'b1;
			loc       <= 17'h00000;
			word_out  <= 16'h0000;
			word_oe   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy_r) begin
				if (start) begin
					busy_r    <= 1'b1;
					wr_r      <= is_write;
					cnt_r     <= 3'h0;
					loc       <= addr;
					word_out  <= wdata;
					dev_sel_n <= ~sel;
					word_oe   <= is_write;
				end
			end else begin
				cnt_r <= cnt_r + 3'h1;
				if (cnt_r == 3'h0) begin
					// address latched by device on this fall
					if (wr_r)
						we_n <= 1'b0;
					else
						oe_n <= 1'b0;
				end else if (cnt_r == 3'(flash_host_pkg::PULSE_CYC)) begin
					// data latched by device on this rise
					we_n <= 1'b1;
					oe_n <= 1'b1;
					if (!wr_r)
						rdata <= word_in;
				end else if (cnt_r == 3'(flash_host_pkg::PULSE_CYC + 1)) begin
					dev_sel_n <= 4'hF;
					word_oe   <= 1'b0;
					busy_r    <= 1'b0;
					done      <= 1'b1;
				end
			end
		end
	end
endmodule

// *** verilog/flash_host.sv ***
`timescale 1ns/10ps
// Contract
// - At high supply host writes 00H before array reads.
// - 40H arms program; next write carries address and data.
// - Host writes C0H after programming; its rise ends the pulse.
// - After C0H host waits 6us, then reads and compares.
// - Failed verify repeats program and verify, 25 tries total.
// - Two consecutive 20H writes start whole-device erase.
// - Host programs all locations to 00H before erase; this host skips that pass and starts with the 20H writes.
// - Parallel erase writes 2020H twice, waits 10ms, writes A0A0H.
// - Lanes checked separately; failure re-erases at same address.
// - Verified lane is masked with FFH in erase and verify words.
// - Both lanes verified: unmask, advance address, verify again.
// - Erase verify opens with A0H write latching the address.
// - FFH read means erased; reissue verify per location.
// - Failed erase verify erases again, resumes at stopped location.
// - After full verify host exits with another valid command.
module flash_host (
	input  wire logic                                  mclk,         // 40 MHz clock
	input  wire logic                                  rst_n,        // async reset
	input  wire logic                                  cmd_valid,    // start operation
	input  wire flash_host_pkg::op_e                   cmd_op,       // operation
	input  wire logic [1:0]                            cmd_dev,      // device for single ops
	input  wire logic [flash_host_pkg::ADDR_W-1:0]     cmd_addr,     // location
	input  wire logic [flash_host_pkg::LANE_W-1:0]     cmd_data,     // program byte
	input  wire logic                                  supply_high,  // programming supply up
	input  wire logic [flash_host_pkg::WORD_W-1:0]     word_in,      // word_lines input
	output logic                                       cmd_ready,    // idle, accepts command
	output logic                                       rsp_valid,    // operation done pulse
	output logic                                       rsp_fail,     // operation failed
	output logic [flash_host_pkg::LANE_W-1:0]          rsp_data,     // read byte
	output logic [flash_host_pkg::NDEV-1:0]            device_select_n, // chip enables
	output logic                                       we_n,         // write enable
	output logic                                       oe_n,         // output enable
	output logic [flash_host_pkg::ADDR_W-1:0]          location_lines,  // address
	output logic [flash_host_pkg::WORD_W-1:0]          word_out,     // word_lines output
	output logic                                       word_oe       // word_lines enable
);
	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_RDCMD  = 4'b0001,
		S_RDARR  = 4'b0010,
		S_PSETUP = 4'b0011,
		S_PDATA  = 4'b0100,
		S_PVCMD  = 4'b0101,
		S_PVRD   = 4'b0110,
		S_ESET   = 4'b0111,
		S_EGO    = 4'b1000,
		S_EVCMD  = 4'b1001,
		S_EVRD   = 4'b1010,
		S_EXIT   = 4'b1011,
		S_DONE   = 4'b1100,
		S_WAIT   = 4'b1101
	} state_e;

	state_e                              state_r;
	state_e                              after_r;
	logic [flash_host_pkg::TIMER_W-1:0]  timer_r;
	logic [flash_host_pkg::TRY_W-1:0]    tries_r;
	logic [flash_host_pkg::ADDR_W-1:0]   addr_r;
	logic [flash_host_pkg::LANE_W-1:0]   data_r;
	logic [1:0]                          dev_r;
	logic                                par_r;
	logic [1:0]                          lane_ok_r;
	logic                                fail_r;
	logic                                own_r;
	logic                                cyc_start_r;
	logic                                cyc_wr_r;
	logic [flash_host_pkg::WORD_W-1:0]   cyc_wdata_r;
	logic [flash_host_pkg::NDEV-1:0]     sel;
	logic                                cyc_done;
	logic [flash_host_pkg::WORD_W-1:0]   cyc_rdata;

	// place a command byte in the lane of the addressed device, reset code masks a lane
	function automatic logic [15:0] lane_word(input logic [1:0] dev, input logic [7:0] b);
		lane_word = dev[0] ? {b, flash_host_pkg::CMD_RESET} : {flash_host_pkg::CMD_RESET, b};
	endfunction

	// byte of the addressed device's lane
	function automatic logic [7:0] lane_byte(input logic [1:0] dev, input logic [15:0] w);
		lane_byte = dev[0] ? w[15:8] : w[7:0];
	endfunction

	// per-lane command: verified lanes get the reset code
	function automatic logic [15:0] par_word(input logic [1:0] ok, input logic [7:0] b);
		par_word = {ok[1] ? flash_host_pkg::CMD_RESET : b, ok[0] ? flash_host_pkg::CMD_RESET : b};
	endfunction

	// single device select, or the low pair for a word-wide erase
	assign sel = par_r ? 4'h3 : (4'h1 << dev_r);

	flash_bus_cycle u_cyc (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.start     (cyc_start_r),
		.is_write  (cyc_wr_r),
		.sel       (sel),
		.addr      (addr_r),
		.wdata     (cyc_wdata_r),
		.word_in   (word_in),
		.done      (cyc_done),
		.rdata     (cyc_rdata),
		.dev_sel_n (device_select_n),
		.we_n      (we_n),
		.oe_n      (oe_n),
		.loc       (location_lines),
		.word_out  (word_out),
		.word_oe   (word_oe)
	);

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	task automatic issue(input logic wr, input logic [15:0] w, input state_e nxt);
		cyc_start_r <= 1'b1;
		own_r       <= (nxt == state_r);
		cyc_wr_r    <= wr;
		cyc_wdata_r <= w;
		state_r     <= S_WAIT;
		after_r     <= nxt;
	endtask

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= S_IDLE;
			after_r     <= S_IDLE;
			timer_r     <= '0;
			tries_r     <= '0;
			addr_r      <= 17'h00000;
			data_r      <= 8'h00;
			dev_r       <= 2'h0;
			par_r       <= 1'b0;
			lane_ok_r   <= 2'h0;
			fail_r      <= 1'b0;
			own_r       <= 1'b0;
			cyc_start_r <= 1'b0;
			cyc_wr_r    <= 1'b0;
			cyc_wdata_r <= 16'h0000;
			cmd_ready   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_fail    <= 1'b0;
			rsp_data    <= 8'h00;
		end else begin
			cyc_start_r <= 1'b0;
			own_r       <= 1'b0;
			rsp_valid   <= 1'b0;
			cmd_ready   <= 1'b0;
			if (timer_r != '0)
				timer_r <= timer_r - 1'b1;
			case (state_r)
				S_IDLE: begin
					cmd_ready <= !cmd_valid;
					if (cmd_valid) begin
						addr_r    <= cmd_addr;
						data_r    <= cmd_data;
						dev_r     <= cmd_dev;
						par_r     <= (cmd_op == flash_host_pkg::OP_PERASE);
						lane_ok_r <= 2'h0;
						tries_r   <= '0;
						fail_r    <= 1'b0;
						case (cmd_op)
							flash_host_pkg::OP_READ: state_r <= supply_high ? S_RDCMD : S_RDARR;
							flash_host_pkg::OP_PROGRAM: state_r <= S_PSETUP;
							default: begin
								addr_r  <= flash_host_pkg::ZERO_ADDR;
								state_r <= S_ESET;
							end
						endcase
						if (!supply_high && cmd_op != flash_host_pkg::OP_READ) begin
							fail_r  <= 1'b1;
							state_r <= S_DONE;
						end
					end
				end
				S_RDCMD: issue(1'b1, lane_word(dev_r, flash_host_pkg::CMD_READ), S_RDARR);
				S_RDARR: if (own_r) begin
					data_r  <= lane_byte(dev_r, cyc_rdata);
					after_r <= S_IDLE;
					state_r <= S_DONE;
				end else
					issue(1'b0, 16'h0000, S_RDARR);
				S_PSETUP: issue(1'b1, lane_word(dev_r, flash_host_pkg::CMD_PROG), S_PDATA);
				S_PDATA: issue(1'b1, lane_word(dev_r, data_r), S_PVCMD);
				S_PVCMD: if (own_r) begin
					// write issued; margin settle
					timer_r <= flash_host_pkg::TIMER_W'(flash_host_pkg::PVFY_CYC);
					after_r <= S_PVRD;
				end else if (after_r == S_PVRD) begin
					if (timer_r == '0)
						issue(1'b0, 16'h0000, S_PVRD);
				end else
					issue(1'b1, lane_word(dev_r, flash_host_pkg::CMD_PVFY), S_PVCMD);
				S_PVRD: begin
					tries_r <= tries_r + 1'b1;
					if (lane_byte(dev_r, cyc_rdata) == data_r)
						state_r <= S_EXIT;
					else if (tries_r == flash_host_pkg::TRY_W'(flash_host_pkg::MAX_PROG_TRY - 1)) begin
						fail_r  <= 1'b1;
						state_r <= S_EXIT;
					end else
						state_r <= S_PSETUP;
				end
				S_ESET: issue(1'b1, par_r ? par_word(lane_ok_r, flash_host_pkg::CMD_ERASE)
					: lane_word(dev_r, flash_host_pkg::CMD_ERASE), S_EGO);
				S_EGO: if (own_r) begin
					timer_r <= flash_host_pkg::TIMER_W'(flash_host_pkg::ERASE_CYC);
					after_r <= S_EVCMD;
				end else if (after_r == S_EVCMD) begin
					if (timer_r == '0)
						state_r <= S_EVCMD;
				end else
					issue(1'b1, par_r ? par_word(lane_ok_r, flash_host_pkg::CMD_ERASE)
						: lane_word(dev_r, flash_host_pkg::CMD_ERASE), S_EGO);
				S_EVCMD: if (own_r) begin
					timer_r <= flash_host_pkg::TIMER_W'(flash_host_pkg::PVFY_CYC);
					after_r <= S_EVRD;
				end else if (after_r == S_EVRD) begin
					if (timer_r == '0)
						issue(1'b0, 16'h0000, S_EVRD);
				end else
					issue(1'b1, par_r ? par_word(lane_ok_r, flash_host_pkg::CMD_EVFY)
						: lane_word(dev_r, flash_host_pkg::CMD_EVFY), S_EVCMD);
				S_EVRD: begin
					logic [1:0] ok;
					ok = lane_ok_r;
					if (par_r) begin
						ok[0] = lane_ok_r[0] | (cyc_rdata[7:0] == flash_host_pkg::ERASED);
						ok[1] = lane_ok_r[1] | (cyc_rdata[15:8] == flash_host_pkg::ERASED);
					end else
						ok = {2{lane_byte(dev_r, cyc_rdata) == flash_host_pkg::ERASED}};
					if (&ok) begin
						lane_ok_r <= 2'h0;
						if (addr_r == flash_host_pkg::LAST_ADDR)
							state_r <= S_EXIT;
						else begin
							addr_r  <= addr_r + 1'b1;
							after_r <= S_IDLE;
							state_r <= S_EVCMD;
						end
					end else begin
						lane_ok_r <= ok;
						after_r   <= S_IDLE;
						state_r   <= S_ESET;
					end
				end
				S_EXIT: issue(1'b1, par_r ? {flash_host_pkg::CMD_READ, flash_host_pkg::CMD_READ}
					: lane_word(dev_r, flash_host_pkg::CMD_READ), S_DONE);
				S_DONE: begin
					rsp_valid <= 1'b1;
					rsp_fail  <= fail_r;
					rsp_data  <= data_r;
					state_r   <= S_IDLE;
				end
				S_WAIT: begin
					// remember whether the cycle was issued by its own return state
					own_r <= own_r;
					if (cyc_done)
						state_r <= after_r;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule
